/* File: pfc_port1_flow_control.sv */
// Port 1 flow-control configuration and status register bank, APB slave
//
// Behaviour
// - The back-pressure enable at bit 6 gates half-duplex forced-collision generation on port 1.
// - Read-only bit 5 returns the live duplex of port 1, 0 full and 1 half.
// - Read-only bit 4 shows whether pause reception is active, from manual or negotiated setup.
// - Read-only bit 3 shows whether pause transmission is active, from manual or negotiated setup.
// - With manual select set or autonegotiation off, bit 2 enables detection of received pause frames.
// - With manual select set or autonegotiation off, bit 1 enables generation of pause frames.
// - Manual select clear with autonegotiation on takes the negotiated result, otherwise the enable bits.
// - Manual select set makes the enable bits govern flow control in full duplex over the negotiation.
// - Reset defaults of the writable bits come from the strap values sampled at reset.
// - An EEPROM loader rewrite of the straps updates the writable and derived bits.
// - Writes here never touch the PHY autonegotiation advertisement bits.
// - Generated pause frames carry the station address held in the high and low address registers.
`timescale 1ns/1ps
`default_nettype none
module pfc_port1_flow_control
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        port1_backpressure_strap,
   input  wire logic        port1_full_duplex_pause_strap,
   input  wire logic        port1_manual_select_strap,
   input  wire logic        strap_reload,
   input  wire logic        phy1_autoneg_enable,
   input  wire logic        phy1_half_duplex,
   input  wire logic        phy1_partner_pause,
   input  wire logic        phy1_partner_asym_pause,
   input  wire logic        phy1_local_asym_pause,
   output logic             port1_backpressure_active,
   output logic             port1_pause_receive_active,
   output logic             port1_pause_transmit_active,
   output logic [47:0]      pause_source_addr
);

   // ==========================================================
   // Input synchronisers (three stages, second and third agree)
   // ==========================================================
   // Zero reset keeps straps unread until the settle counter captures them
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] sync3_reg;
   logic [7:0] clean_reg;
   logic [7:0] raw_in;

   assign raw_in = {phy1_local_asym_pause, phy1_partner_asym_pause, phy1_partner_pause,
                    phy1_half_duplex, phy1_autoneg_enable, port1_manual_select_strap,
                    port1_full_duplex_pause_strap, port1_backpressure_strap};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
         sync3_reg <= 8'h00;
      end
      else
      begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Bits settle only once two stages agree, so a mid-change sample is held off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clean_reg <= 8'h00;
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (sync2_reg[i] == sync3_reg[i])
               clean_reg[i] <= sync3_reg[i];
         end
      end
   end

   logic bp_strap;
   logic fd_strap;
   logic man_strap;
   logic an_enable;
   logic half_duplex;
   logic partner_pause;
   logic partner_asym;
   logic local_asym;
   assign bp_strap      = clean_reg[0];
   assign fd_strap      = clean_reg[1];
   assign man_strap     = clean_reg[2];
   assign an_enable     = clean_reg[3];
   assign half_duplex   = clean_reg[4];
   assign partner_pause = clean_reg[5];
   assign partner_asym  = clean_reg[6];
   assign local_asym    = clean_reg[7];

   // ==========================================================
   // Strap capture after reset release and on loader rewrite
   // ==========================================================
   // Straps need the synchroniser pipeline to fill before they are trusted
   logic [2:0] settle_reg;
   logic       settle_done;
   logic       strap_load;
   logic       reload_seen_reg;
   logic       reload_edge;

   assign settle_done = settle_reg == pfc_pkg::STRAP_SETTLE_DONE;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         settle_reg <= 3'h0;
      else if (!settle_done)
         settle_reg <= settle_reg + 3'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reload_seen_reg <= 1'b0;
      else
         reload_seen_reg <= strap_reload;
   end

   // Reload is a same-clock pulse from the loader; delay it so the clean straps are current
   assign reload_edge = reload_seen_reg;
   assign strap_load  = (settle_reg == pfc_pkg::STRAP_CAPTURE_COUNT) || reload_edge;

   // ==========================================================
   // APB access
   // ==========================================================
   logic access;
   logic wr_en;
   logic fc_hit;
   logic addr_low_hit;
   logic addr_high_hit;
   logic link_hit;
   logic mapped;

   assign access        = psel && penable;
   assign fc_hit        = paddr == pfc_pkg::PORT1_FLOW_CONTROL_OFFSET;
   assign addr_low_hit  = paddr == pfc_pkg::STATION_ADDR_LOW_OFFSET;
   assign addr_high_hit = paddr == pfc_pkg::STATION_ADDR_HIGH_OFFSET;
   assign link_hit      = paddr == pfc_pkg::PORT1_LINK_STATUS_OFFSET;
   assign mapped        = fc_hit || addr_low_hit || addr_high_hit || link_hit;
   assign wr_en         = access && pwrite && mapped;
   // No wait states: every register answers in its access cycle
   assign pready        = 1'b1;
   // Unmapped offsets report an error and change nothing
   assign pslverr       = access && !mapped;

   // ==========================================================
   // Writable flow-control bits
   // ==========================================================
   logic backpressure_enable_reg;
   logic pause_receive_enable_reg;
   logic pause_transmit_enable_reg;
   logic manual_select_reg;
   logic fc_write;

   assign fc_write = wr_en && fc_hit && pstrb[pfc_pkg::PSTRB_LANE_LOW];

   // writes act immediately
   // A strap load beats a write in the same cycle so loader values are never lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         backpressure_enable_reg   <= 1'b0;
         pause_receive_enable_reg  <= 1'b0;
         pause_transmit_enable_reg <= 1'b0;
         manual_select_reg         <= 1'b0;
      end
      else if (strap_load)
      begin
         backpressure_enable_reg   <= bp_strap;
         pause_receive_enable_reg  <= fd_strap;
         pause_transmit_enable_reg <= fd_strap;
         manual_select_reg         <= man_strap;
      end
      else if (fc_write)
      begin
         backpressure_enable_reg   <= pwdata[pfc_pkg::FC_BACKPRESSURE_BIT];
         pause_receive_enable_reg  <= pwdata[pfc_pkg::FC_RX_ENABLE_BIT];
         pause_transmit_enable_reg <= pwdata[pfc_pkg::FC_TX_ENABLE_BIT];
         manual_select_reg         <= pwdata[pfc_pkg::FC_MANUAL_SELECT_BIT];
      end
   end

   // ==========================================================
   // Station address for pause frames
   // ==========================================================
   // Resets to all ones; software programs the station address before enabling pause
   logic [15:0] station_addr_high_reg;
   logic [31:0] station_addr_low_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         station_addr_low_reg <= pfc_pkg::STATION_ADDR_LOW_RESET;
      else if (wr_en && addr_low_hit)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (pstrb[b])
               station_addr_low_reg[8*b +: 8] <= pwdata[8*b +: 8];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         station_addr_high_reg <= pfc_pkg::STATION_ADDR_HIGH_RESET;
      else if (wr_en && addr_high_hit)
      begin
         // Only byte lanes 0 and 1 exist in the upper address half
         for (int b = 0; b < 2; b++)
         begin
            if (pstrb[b])
               station_addr_high_reg[8*b +: 8] <= pwdata[8*b +: 8];
         end
      end
   end

   assign pause_source_addr = {station_addr_high_reg, station_addr_low_reg};

   // ==========================================================
   // Flow-control resolution
   // ==========================================================
   logic neg_rx;
   logic neg_tx;
   logic use_manual;
   logic active_rx;
   logic active_tx;

   // Standard pause resolution from local and partner abilities; local always offers symmetric pause
   always_comb
   begin
      neg_rx = partner_pause || (local_asym && partner_asym && !partner_pause);
      neg_tx = partner_pause;
   end

   assign use_manual = manual_select_reg || !an_enable;

   assign active_rx = !half_duplex && (use_manual ? pause_receive_enable_reg : neg_rx);
   assign active_tx = !half_duplex && (use_manual ? pause_transmit_enable_reg : neg_tx);

   // ==========================================================
   // Registered status outputs
   // ==========================================================
   logic bp_active_reg;
   logic rx_active_reg;
   logic tx_active_reg;
   logic duplex_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bp_active_reg <= 1'b0;
         rx_active_reg <= 1'b0;
         tx_active_reg <= 1'b0;
         duplex_reg    <= 1'b0;
      end
      else
      begin
         bp_active_reg <= backpressure_enable_reg && half_duplex;
         rx_active_reg <= active_rx;
         tx_active_reg <= active_tx;
         duplex_reg    <= half_duplex;
      end
   end

   assign port1_backpressure_active   = bp_active_reg;
   assign port1_pause_receive_active  = rx_active_reg;
   assign port1_pause_transmit_active = tx_active_reg;

   // ==========================================================
   // Read data
   // ==========================================================
   logic [31:0] read_value;

   always_comb
   begin
      read_value = 32'h00000000;
      if (fc_hit)
      begin
         read_value[pfc_pkg::FC_BACKPRESSURE_BIT]  = backpressure_enable_reg;
         read_value[pfc_pkg::FC_DUPLEX_BIT]        = duplex_reg;
         read_value[pfc_pkg::FC_ACTIVE_RX_BIT]     = rx_active_reg;
         read_value[pfc_pkg::FC_ACTIVE_TX_BIT]     = tx_active_reg;
         read_value[pfc_pkg::FC_RX_ENABLE_BIT]     = pause_receive_enable_reg;
         read_value[pfc_pkg::FC_TX_ENABLE_BIT]     = pause_transmit_enable_reg;
         read_value[pfc_pkg::FC_MANUAL_SELECT_BIT] = manual_select_reg;
      end
      else if (addr_low_hit)
         read_value = station_addr_low_reg;
      else if (addr_high_hit)
         read_value[15:0] = station_addr_high_reg;
      else if (link_hit)
      begin
         // Link status is a read-only view of the synchronised PHY inputs
         read_value[pfc_pkg::LINK_AUTONEG_EN_BIT]    = an_enable;
         read_value[pfc_pkg::LINK_HALF_DUPLEX_BIT]   = half_duplex;
         read_value[pfc_pkg::LINK_PARTNER_PAUSE_BIT] = partner_pause;
         read_value[pfc_pkg::LINK_PARTNER_ASYM_BIT]  = partner_asym;
         read_value[pfc_pkg::LINK_LOCAL_ASYM_BIT]    = local_asym;
      end
   end

   // Read data is registered in the setup cycle so it is stable through the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= read_value;
   end

endmodule
`default_nettype wire

/* File: pfc_pkg.sv */
// Package: offsets, field positions and defaults for the port 1 flow-control register bank
package pfc_pkg;
   localparam logic [11:0] PORT1_FLOW_CONTROL_OFFSET = 12'h1a0;
   localparam logic [11:0] STATION_ADDR_LOW_OFFSET   = 12'h1ac;
   localparam logic [11:0] STATION_ADDR_HIGH_OFFSET  = 12'h1b0;
   localparam logic [11:0] PORT1_LINK_STATUS_OFFSET  = 12'h1b4;
   localparam int FC_MANUAL_SELECT_BIT   = 0;
   localparam int FC_TX_ENABLE_BIT       = 1;
   localparam int FC_RX_ENABLE_BIT       = 2;
   localparam int FC_ACTIVE_TX_BIT       = 3;
   localparam int FC_ACTIVE_RX_BIT       = 4;
   localparam int FC_DUPLEX_BIT          = 5;
   localparam int FC_BACKPRESSURE_BIT    = 6;
   localparam int LINK_AUTONEG_EN_BIT    = 0;
   localparam int LINK_HALF_DUPLEX_BIT   = 1;
   localparam int LINK_PARTNER_PAUSE_BIT = 2;
   localparam int LINK_PARTNER_ASYM_BIT  = 3;
   localparam int LINK_LOCAL_ASYM_BIT    = 4;
   localparam logic [15:0] STATION_ADDR_HIGH_RESET = 16'hffff;
   localparam logic [31:0] STATION_ADDR_LOW_RESET  = 32'hffffffff;
   localparam logic [1:0] PSTRB_LANE_LOW  = 2'h0;
   localparam logic [2:0] STRAP_CAPTURE_COUNT = 3'h4;
   localparam logic [2:0] STRAP_SETTLE_DONE   = 3'h5;
endpackage

/* File: pfc_fc_assertions.sv */
// Checker for the port 1 flow-control register bank
`timescale 1ns/1ps
`default_nettype none
module pfc_fc_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        strap_reload,
   input wire logic        phy1_half_duplex,
   input wire logic        port1_backpressure_active,
   input wire logic        port1_pause_receive_active,
   input wire logic        port1_pause_transmit_active,
   input wire logic [47:0] pause_source_addr
);
   wire logic acc = psel && penable;
   wire logic hit = paddr inside {12'h1a0, 12'h1ac, 12'h1b0, 12'h1b4};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====================================
   // Bus decode
   a_err_decode: assert property (acc |-> pslverr == !hit) else $error("bad slave error");
   a_err_idle: assert property (!acc |-> !pslverr) else $error("slave error outside access");
   a_unmapped_zero: assert property (acc && !pwrite && !hit |-> prdata == '0) else $error("unmapped read");
   a_reserved_zero: assert property (acc && !pwrite && paddr == 12'h1a0 |-> prdata[31:7] == '0)
      else $error("reserved bits set");
   // ====================================
   // Flow control outputs
   // Eight cycles of half duplex outlast the input synchroniser
   a_half_no_rx: assert property (phy1_half_duplex [*8] |-> !port1_pause_receive_active)
      else $error("pause receive in half duplex");
   a_half_no_tx: assert property (phy1_half_duplex [*8] |-> !port1_pause_transmit_active)
      else $error("pause transmit in half duplex");
   a_full_no_bp: assert property (!phy1_half_duplex [*8] |-> !port1_backpressure_active)
      else $error("backpressure in full duplex");
   // A reload seen one cycle earlier loads the straps over this write, so it is excluded
   a_bp_off: assert property (acc && pwrite && paddr == 12'h1a0 && pstrb[0] && !pwdata[6] && !strap_reload
      && !$past(strap_reload) |-> ##[2:3] !port1_backpressure_active) else $error("backpressure not disabled");
   a_addr_low: assert property (acc && pwrite && paddr == 12'h1ac && pstrb == 4'hf
      |=> pause_source_addr[31:0] == $past(pwdata)) else $error("station address low");
endmodule
bind pfc_port1_flow_control pfc_fc_chk chk
(
   .pclk                        (pclk),
   .presetn                     (presetn),
   .psel                        (psel),
   .penable                     (penable),
   .pwrite                      (pwrite),
   .paddr                       (paddr),
   .pwdata                      (pwdata),
   .pstrb                       (pstrb),
   .prdata                      (prdata),
   .pslverr                     (pslverr),
   .strap_reload                (strap_reload),
   .phy1_half_duplex            (phy1_half_duplex),
   .port1_backpressure_active   (port1_backpressure_active),
   .port1_pause_receive_active  (port1_pause_receive_active),
   .port1_pause_transmit_active (port1_pause_transmit_active),
   .pause_source_addr           (pause_source_addr)
);
`default_nettype wire

/* File: pfc_link_partner.sv */
// Link partner model: presents negotiated link status to the port
`timescale 1ns/1ps
`default_nettype none
module pfc_link_partner
(
   input  wire logic       pclk,
   input  wire logic [4:0] link_cfg,
   output logic      [4:0] link_status
);
   // Status order: local asym, partner asym, partner pause, half duplex, autoneg on
   always_ff @(posedge pclk)
   begin
      link_status <= link_cfg;
   end
endmodule
`default_nettype wire

/* File: pfc_port1_flow_control_tb.sv */
// Testbench for the port 1 flow-control register bank
`timescale 1ns/1ps
`default_nettype none
module pfc_port1_flow_control_tb;
   logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, er;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0]  pstrb = '0;
   logic        pready, pslverr, bps = '1, fds = '1, mss = '0, reload = '0, bpa, rxa, txa;
   logic [4:0]  cfg = '0, ls;
   logic [47:0] src;
   int          bad_count = 0, comparisons = 0;
   always #5 pclk = ~pclk;
   pfc_link_partner lp (.pclk(pclk), .link_cfg(cfg), .link_status(ls));
   pfc_port1_flow_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port1_backpressure_strap(bps), .port1_full_duplex_pause_strap(fds), .port1_manual_select_strap(mss),
      .strap_reload(reload), .phy1_autoneg_enable(ls[0]), .phy1_half_duplex(ls[1]), .phy1_partner_pause(ls[2]),
      .phy1_partner_asym_pause(ls[3]), .phy1_local_asym_pause(ls[4]), .port1_backpressure_active(bpa),
      .port1_pause_receive_active(rxa), .port1_pause_transmit_active(txa), .pause_source_addr(src));
   // ====================================
   // Shared tasks
   task chk(string n, logic [47:0] got, logic [47:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask
   task wt(int n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Reserved bits are written as ones and read-only bits as given in r; they must read back as zero or status
   task setfc(logic [6:0] r, logic [4:0] l);
      logic [1:0] e;
      cfg <= l;
      apb(1'b1, 12'h1a0, {25'h1ffffff, r}, 4'hf);
      wt(10);
      apb(1'b0, 12'h1a0, '0, 4'h0);
      e = l[1] ? 2'b00 : (r[0] || !l[0]) ? r[2:1] : {l[2] | (l[4] & l[3]), l[2]};
      chk("flow reg", rd, {25'h0, r[6], l[1], e, r[2:0]});
      chk("pause active", {rxa, txa}, e);
      chk("backpressure", bpa, r[6] & l[1]);
      apb(1'b0, 12'h1b4, '0, 4'h0);
      chk("link status", rd, {27'h0, l});
   endtask
   // ====================================
   // Scenarios
   task t_defaults;
      chk("ready idle", pready, 1'b1);
      chk("source reset", src, {pfc_pkg::STATION_ADDR_HIGH_RESET, pfc_pkg::STATION_ADDR_LOW_RESET});
      apb(1'b0, 12'h1a0, '0, 4'h0);
      chk("strap defaults", rd, 32'h5e);
   endtask
   task t_manual;
      setfc(7'h3f, 5'b00001);
      setfc(7'h39, 5'b00101);
      setfc(7'h3b, 5'b00101);
      setfc(7'h3d, 5'b00101);
   endtask
   task t_autoneg;
      setfc(7'h06, 5'b00101);
      setfc(7'h06, 5'b11001);
      setfc(7'h00, 5'b00101);
      setfc(7'h04, 5'b00100);
   endtask
   task t_half;
      setfc(7'h47, 5'b00011);
      setfc(7'h07, 5'b00010);
      apb(1'b1, 12'h1a0, '0, 4'he);
      apb(1'b0, 12'h1a0, '0, 4'h0);
      chk("masked write", rd, 32'h27);
   endtask
   task t_errors;
      apb(1'b1, 12'h1bc, 32'h0000007f, 4'hf);
      chk("write error", er, 1'b1);
      apb(1'b0, 12'h1bc, '0, 4'h0);
      chk("unmapped read", rd, 32'h0);
      chk("read error", er, 1'b1);
      apb(1'b1, 12'h1b4, 32'hffffffff, 4'hf);
      chk("status write", er, 1'b0);
      apb(1'b0, 12'h1b4, '0, 4'h0);
      chk("status kept", rd, 32'h02);
   endtask
   task t_reload;
      cfg <= 5'b00000;
      bps <= 1'b0;
      fds <= 1'b0;
      mss <= 1'b1;
      wt(8);
      reload <= 1'b1;
      @(posedge pclk);
      reload <= 1'b0;
      wt(10);
      apb(1'b0, 12'h1a0, '0, 4'h0);
      chk("reloaded reg", rd, 32'h01);
      chk("reloaded active", {rxa, txa, bpa}, 3'h0);
   endtask
   task t_station;
      apb(1'b1, 12'h1ac, 32'h89abcdef, 4'hf);
      apb(1'b1, 12'h1b0, 32'h00004567, 4'hf);
      chk("pause source", src, 48'h456789abcdef);
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wt(10);
      t_defaults;
      t_manual;
      t_autoneg;
      t_half;
      t_errors;
      t_reload;
      t_station;
      conclude;
   end
   // Whole run needs under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      conclude;
   end
endmodule
`default_nettype wire
